// *** hw/fpc_pkg.sv ***
// constants, types and command codes of the four-pair fault/temperature bank
`default_nettype none
package fpc_pkg;

  // command codes that select a register on the host transfer
  localparam logic [7:0] CMD_DIE_TEMP = 8'h2c;
  localparam logic [7:0] CMD_FAULT_CFG = 8'h2d;

  // reset values
  localparam logic [7:0] DIE_TEMP_RESET = 8'h00;
  localparam logic [7:0] FAULT_CFG_RESET = 8'h00;
  localparam logic [7:0] READ_FILL = 8'h00;

  // field positions in the fault configuration byte; port pair p adds p
  localparam int CURRENT_LIMIT_FAULT_GANG_LSB = 6;
  localparam int PCUT_GANG_LSB = 4;
  localparam int SUMMED_EN_LSB = 2;
  localparam int DISC_SEL_LSB = 0;

  localparam int NUM_PAIRS = 2;
  localparam int NUM_CHANS = 4;

  // lowest assigned class that takes the low disconnect threshold
  localparam logic [3:0] HIGH_CLASS_MIN = 4'h5;

  // temperature code scale, offset in hundredths, step in thousandths, span in tenths of a degree: t = -20 + n * 0.652
  localparam int TEMP_OFFSET_CENTI_C = -2000;
  localparam int TEMP_STEP_MILLI_C = 652;
  localparam int TEMP_SPAN_DECI_C = 1462;

  // temperature refresh period and its cycle count
  localparam longint CLK_FREQ_HZ = 100_000_000;
  localparam longint TEMP_REFRESH_MS = 1000;
  localparam longint TEMP_REFRESH_CYCLES_L =
    (TEMP_REFRESH_MS * CLK_FREQ_HZ) / 1000;
  localparam int TEMP_REFRESH_CYCLES = int'(TEMP_REFRESH_CYCLES_L);
  localparam int TICK_CNT_W = 32;

  // operating mode of the port state machines
  typedef enum logic [1:0] {
    MODE_MANUAL,
    MODE_SEMI_AUTO,
    MODE_AUTO
  } fpc_mode_type;

  // one host register transfer, already framed from the serial link
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [7:0] wdata;
  } fpc_cmd_type;

  // per-channel fault and current status from the analog front end
  typedef struct packed {
    logic current_limit_fault;
    logic pcut_2pair_fault;
    logic below_30ma;
    logic mps_expired;
  } fpc_chan_type;

  // per port-pair turn-on event and load description
  typedef struct packed {
    logic turn_on;
    logic single_sig;
    logic dual_sig;
    logic partial_disc;
    logic summed_over;
    logic [3:0] assigned_class;
  } fpc_pair_type;

endpackage
`default_nettype wire

// *** hw/fpc_top.sv ***
// four-pair fault configuration and die temperature register bank
//
// What this block does
// - read-only eight-bit temperature code, zero at reset, one byte per read
// - temperature code refreshes about once a second, repeats in between
// - code n means -20 plus n times 0.652 C, span 146.2 C
// - fault config byte at command 2d, read/write, all bits zero at reset
// - current-limit gang bit set: either channel fault turns both off
// - power-cut gang bit set: either 2-pair power cut turns both off
// - auto mode sets both gang bits at turn-on of single-signature load
// - summed enable bit set turns on summed four-pair policing for port
// - current-limit faults act regardless of summed enable bits
// - auto or semi auto set summed enable at single-signature turn-on
// - threshold select bit: 1 gives 4.5 mA, 0 gives 6.5 mA
// - dual-signature turn-on sets threshold bit; channels disconnect alone
// - single-signature turn-on: class 1-4 clears, class 5-8 sets bit
// - summed policing paused on partial disconnect or channel under 30 mA
`default_nettype none
module fpc_top #(
  parameter int REFRESH_CYCLES = fpc_pkg::TEMP_REFRESH_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fpc_pkg::fpc_cmd_type cmd,
  input wire fpc_pkg::fpc_mode_type op_mode,
  input wire logic [7:0] temp_adc_code,
  input wire logic temp_adc_valid,
  input wire fpc_pkg::fpc_chan_type [3:0] chan_status,
  input wire fpc_pkg::fpc_pair_type [1:0] pair_status,
  output logic [7:0] rd_data_r,
  output logic rd_valid_r,
  output logic [7:0] die_temp_code,
  output logic [7:0] fault_cfg,
  output logic [3:0] chan_disable_r,
  output logic [1:0] summed_policing_active_r,
  output logic [1:0] disconnect_threshold_select
);
  import fpc_pkg::*;

  localparam logic [TICK_CNT_W-1:0] TICK_LAST =
    TICK_CNT_W'(REFRESH_CYCLES - 1);
  localparam logic [TICK_CNT_W-1:0] TICK_ZERO = '0;
  localparam logic [TICK_CNT_W-1:0] TICK_ONE = TICK_CNT_W'(1);

  logic [7:0] die_temp_r;
  logic [7:0] die_temp_nxt;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic [TICK_CNT_W-1:0] tick_cnt_nxt;
  logic refresh_tick;
  logic [7:0] adc_hold_r;
  logic adc_seen_r;

  logic sel_temp;
  logic sel_cfg;
  logic wr_cfg;
  logic rd_req;
  logic [7:0] rd_mux;

  logic [1:0] current_limit_fault_gang;
  logic [1:0] pcut_gang;
  logic [1:0] summed_en;
  logic [1:0] summed_active;
  logic [3:0] disable_nxt;

  // the divider sets the temperature refresh rate
  assign refresh_tick = (tick_cnt_r == TICK_LAST);
  assign tick_cnt_nxt = refresh_tick ? TICK_ZERO : tick_cnt_r + TICK_ONE;

  // the converter may deliver more often; only the last code counts
  always_ff @(posedge mclk) begin
    if (rst) begin
      adc_hold_r <= DIE_TEMP_RESET;
      adc_seen_r <= 1'b0;
    end else if (temp_adc_valid) begin
      adc_hold_r <= temp_adc_code;
      adc_seen_r <= 1'b1;
    end
  end

  // code stays put between ticks so fast polls see repeats
  assign die_temp_nxt = (refresh_tick && adc_seen_r) ? adc_hold_r
                                                     : die_temp_r;

  // command decode of the framed host transfer
  assign sel_temp = (cmd.code == CMD_DIE_TEMP);
  assign sel_cfg = (cmd.code == CMD_FAULT_CFG);
  assign wr_cfg = cmd.valid && cmd.write && sel_cfg;
  assign rd_req = cmd.valid && !cmd.write;

  // read selection; unknown codes and reserved space read as zero
  assign rd_mux = sel_temp ? die_temp_r :
                  sel_cfg ? cfg_r :
                  READ_FILL;

  // field slices, low bit channels 1/2 and high bit channels 3/4
  assign current_limit_fault_gang = cfg_r[CURRENT_LIMIT_FAULT_GANG_LSB +: NUM_PAIRS];
  assign pcut_gang = cfg_r[PCUT_GANG_LSB +: NUM_PAIRS];
  assign summed_en = cfg_r[SUMMED_EN_LSB +: NUM_PAIRS];

  // configuration next value; turn-on updates win over a host write
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_cfg) begin
      cfg_nxt = cmd.wdata;
    end
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (pair_status[p].turn_on && pair_status[p].single_sig) begin
        if (op_mode == MODE_AUTO) begin
          cfg_nxt[CURRENT_LIMIT_FAULT_GANG_LSB + p] = 1'b1;
          cfg_nxt[PCUT_GANG_LSB + p] = 1'b1;
        end
        if (op_mode == MODE_AUTO || op_mode == MODE_SEMI_AUTO) begin
          cfg_nxt[SUMMED_EN_LSB + p] = 1'b1;
        end
        // class 5-8 takes the low threshold, class 1-4 the high one
        cfg_nxt[DISC_SEL_LSB + p] =
          (pair_status[p].assigned_class >= HIGH_CLASS_MIN);
      end else if (pair_status[p].turn_on && pair_status[p].dual_sig) begin
        cfg_nxt[DISC_SEL_LSB + p] = 1'b1;
      end
    end
  end

  // summed policing is paused while any channel reading is unreliable
  always_comb begin
    summed_active = '0;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      summed_active[p] = summed_en[p]
        && !pair_status[p].partial_disc
        && !chan_status[2*p].below_30ma
        && !chan_status[2*p+1].below_30ma;
    end
  end

  // channel shutdown: own faults always, partner faults when ganged
  always_comb begin
    disable_nxt = '0;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      for (int k = 0; k < 2; k++) begin
        disable_nxt[2*p+k] =
          // current limit is watched whatever summed policing says
          chan_status[2*p+k].current_limit_fault
          || (current_limit_fault_gang[p]
              && chan_status[2*p+1-k].current_limit_fault)
          || chan_status[2*p+k].pcut_2pair_fault
          || (pcut_gang[p]
              && chan_status[2*p+1-k].pcut_2pair_fault)
          || (summed_active[p] && pair_status[p].summed_over)
          // disconnect timing is judged per channel, never ganged
          || chan_status[2*p+k].mps_expired;
      end
    end
  end

  // state registers of the bank
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt_r <= TICK_ZERO;
      die_temp_r <= DIE_TEMP_RESET;
      cfg_r <= FAULT_CFG_RESET;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      die_temp_r <= die_temp_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // read answer one cycle after the request, one byte per transfer
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_r <= READ_FILL;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_req;
      rd_data_r <= rd_req ? rd_mux : rd_data_r;
    end
  end

  // shutdown and policing outputs, registered for clean timing
  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_disable_r <= '0;
      summed_policing_active_r <= '0;
    end else begin
      chan_disable_r <= disable_nxt;
      summed_policing_active_r <= summed_active;
    end
  end

  // these outputs are plain views of flip-flops
  assign die_temp_code = die_temp_r;
  assign fault_cfg = cfg_r;
  // 1 selects 4.5 mA, 0 selects 6.5 mA in the analog comparator
  assign disconnect_threshold_select =
    cfg_r[DISC_SEL_LSB +: NUM_PAIRS];

endmodule
`default_nettype wire

// *** test/fpc_props.sv ***
// checker for the fault config and temperature bank
`default_nettype none
module fpc_props #(
  parameter int REFRESH_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fpc_pkg::fpc_cmd_type cmd,
  input wire fpc_pkg::fpc_mode_type op_mode,
  input wire fpc_pkg::fpc_chan_type [3:0] chan_status,
  input wire fpc_pkg::fpc_pair_type [1:0] pair_status,
  input wire logic [7:0] rd_data_r,
  input wire logic rd_valid_r,
  input wire logic [7:0] fault_cfg,
  input wire logic [3:0] chan_disable_r,
  input wire logic [1:0] summed_policing_active_r,
  input wire logic [1:0] disconnect_threshold_select
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff rst;
  // request terms; a same-cycle turn-on may override a host write
  wire logic rd_q = cmd.valid & ~cmd.write;
  wire logic wr_q = cmd.valid & cmd.write & (cmd.code == CMD_FAULT_CFG)
    & ~pair_status[0].turn_on & ~pair_status[1].turn_on;
  wire logic sum_ok = fault_cfg[2] & ~pair_status[0].partial_disc
    & ~chan_status[0].below_30ma & ~chan_status[1].below_30ma;
  a_rd_answer: assert property (rd_q |=> rd_valid_r)
    else $error("read not answered");
  a_cfg_read: assert property (rd_q && cmd.code == CMD_FAULT_CFG
    |=> rd_data_r == $past(fault_cfg)) else $error("bad cfg read");
  a_cfg_write: assert property (wr_q |=> fault_cfg == $past(cmd.wdata))
    else $error("cfg write lost");
  a_current_limit_fault_gang: assert property (chan_status[0].current_limit_fault
    && fault_cfg[6] |=> chan_disable_r[1]) else $error("no current_limit_fault gang");
  a_pcut_gang: assert property (chan_status[3].pcut_2pair_fault
    && fault_cfg[5] |=> chan_disable_r[2]) else $error("no pcut gang");
  a_sum_gate: assert property (1'b1
    |=> summed_policing_active_r[0] == $past(sum_ok))
    else $error("summed gate wrong");
  a_thr_map: assert property (
    disconnect_threshold_select == fault_cfg[1:0])
    else $error("threshold bits wrong");
  a_auto_sets: assert property (pair_status[1].turn_on
    && pair_status[1].single_sig && op_mode == MODE_AUTO
    |=> fault_cfg[7] && fault_cfg[5] && fault_cfg[3])
    else $error("no auto set");
  a_class_sel: assert property (pair_status[0].turn_on
    && pair_status[0].single_sig |=> fault_cfg[0] ==
    ($past(pair_status[0].assigned_class) >= HIGH_CLASS_MIN))
    else $error("class threshold wrong");
  c_read: cover property (rd_valid_r);
  c_gang: cover property (chan_disable_r == 4'hc);
  c_auto: cover property (pair_status[1].turn_on && op_mode == MODE_AUTO);
endmodule
`default_nettype wire

// *** test/fpc_host.sv ***
// host model framing single-byte register transfers
`default_nettype none
module fpc_host (
  input wire logic mclk,
  output var fpc_pkg::fpc_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;
  initial cmd = '0;
  // one code and one byte; idle fields flip so stale bytes never match
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [7:0] d);
    @(posedge mclk);
    cmd <= '{1'b1, w, c, d};
    @(posedge mclk);
    cmd <= '{1'b0, ~w, ~c, ~d};
  endtask
endmodule
`default_nettype wire

// *** test/fpc_top_tb_top.sv ***
// self-checking bench for the fault config and temperature bank
`default_nettype none
module fpc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;
  localparam int RC = 16;
  logic mclk = 0, rst = 1, temp_adc_valid = 0, rd_valid_r;
  logic [7:0] temp_adc_code = '0, rd_data_r, die_temp_code, fault_cfg, e, v;
  fpc_mode_type op_mode = MODE_MANUAL;
  fpc_cmd_type cmd;
  fpc_chan_type [3:0] chan_status = '0;
  fpc_pair_type [1:0] pair_status = '0;
  logic [3:0] chan_disable_r;
  logic [1:0] summed_policing_active_r, disconnect_threshold_select;
  logic [7:0] exp_q[$];
  int n_fail = 0, checks = 0, seed = 58814, p, g, k, m;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  fpc_top #(.REFRESH_CYCLES(RC)) fpc_top_i (.*);
  fpc_host fpc_host_i (.mclk, .cmd);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, seen, want);
    end
  endtask
  // reads note their expected byte before the request goes out
  task automatic rd(input logic [7:0] c, input logic [7:0] want);
    exp_q.push_back(want);
    fpc_host_i.xfer(1'b0, c, 8'h00);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // answers land on the rising edge, so look mid-cycle
  always @(negedge mclk) begin
    if (rd_valid_r === 1'b1) check(rd_data_r, exp_q.pop_front());
  end
  // hang guard, far above the run length
  initial begin
    #100us;
    n_fail++;
    results();
  end
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(1);
    check(fault_cfg, FAULT_CFG_RESET);
    rd(CMD_DIE_TEMP, DIE_TEMP_RESET);
    repeat (4) begin
      v = 8'($random(seed));
      fpc_host_i.xfer(1'b1, CMD_FAULT_CFG, v);
      fpc_host_i.xfer(1'b1, CMD_DIE_TEMP, ~v);
      rd(CMD_FAULT_CFG, v);
    end
    // converter byte is held, then shown at the next refresh
    v = 8'($random(seed));
    temp_adc_code <= v;
    temp_adc_valid <= 1'b1;
    tick(1);
    temp_adc_valid <= 1'b0;
    temp_adc_code <= ~v;
    tick(2 * RC);
    check(die_temp_code, v);
    rd(CMD_DIE_TEMP, v);
    rd(CMD_DIE_TEMP, v);
    // fault on the upper channel of each pair, gang bit off and on
    for (k = 0; k < 4; k++) begin
      for (p = 0; p < 2; p++) begin
        e = (k[0] ? 8'h03 : 8'h02) << 2 * p;
        v = 8'h0c | ({7'h0, k[0]} << ((k[1] ? 4 : 6) + p));
        fpc_host_i.xfer(1'b1, CMD_FAULT_CFG, v);
        chan_status[2*p+1].current_limit_fault <= ~k[1];
        chan_status[2*p+1].pcut_2pair_fault <= k[1];
        tick(2);
        check({4'h0, chan_disable_r}, e);
        chan_status <= '0;
      end
    end
    // summed policing trips both channels, paused under 30 mA
    for (p = 0; p < 2; p++) begin
      fpc_host_i.xfer(1'b1, CMD_FAULT_CFG, 8'h04 << p);
      pair_status[p].summed_over <= 1'b1;
      tick(3);
      check({4'h0, chan_disable_r}, 8'h03 << 2 * p);
      check({6'h0, summed_policing_active_r}, 8'h01 << p);
      chan_status[2*p].below_30ma <= 1'b1;
      tick(3);
      check({4'h0, chan_disable_r}, 8'h00);
      check({6'h0, summed_policing_active_r}, 8'h00);
      chan_status <= '0;
      pair_status <= '0;
    end
    // disconnect timing drops only its own channel, gang bits set
    fpc_host_i.xfer(1'b1, CMD_FAULT_CFG, 8'hff);
    chan_status[1].mps_expired <= 1'b1;
    tick(2);
    check({4'h0, chan_disable_r}, 8'h02);
    chan_status <= '0;
    // turn-on in every mode, both pairs, single and dual loads
    for (m = 0; m < 3; m++) begin
      for (p = 0; p < 2; p++) begin
        for (g = 0; g < 2; g++) begin
          v = 8'($random(seed));
          v = {5'h0, v[2:0]} + 8'h01;
          e = (m == 2 ? 8'h54 : m == 1 ? 8'h04 : 8'h00);
          e = (g[0] ? 8'h01 : e | {7'h0, v[3:0] >= 4'h5}) << p;
          fpc_host_i.xfer(1'b1, CMD_FAULT_CFG, 8'h00);
          op_mode <= fpc_mode_type'(m);
          pair_status[p] <= '{1'b1, ~g[0], g[0], 1'b0, 1'b0, v[3:0]};
          tick(1);
          pair_status[p].turn_on <= 1'b0;
          tick(1);
          check(fault_cfg, e);
          check({6'h0, disconnect_threshold_select}, e & 8'h03);
        end
      end
    end
    rd(CMD_FAULT_CFG, e);
    rd(8'h7f, READ_FILL);
    tick(3);
    results();
  end
endmodule
bind fpc_top fpc_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) fpc_props_i (.*);
`default_nettype wire
